// ### rtl/wdog_top.v
/*
 * Output watchdog supervisor top: AHB-Lite register slave, 32-bit
 * timeout counter in 25 ns ticks, expiry latch, per-channel output
 * override, operation lockout, interrupts and the reset button.
 * Assumes one 250 MHz clock, a single AHB-Lite master, and that the
 * network-link input comes from another domain.
 */
`timescale 1ns/10ps
`include "wdog_regs.vh"
module wdog_top #(
   parameter [31:0] HOLD_CYC = `HOLD_CYC_DEF
) (
   // clock and reset
   input  wire        I_MCLK,
   input  wire        I_RST_B,
   // ahb-lite slave
   input  wire        I_HSEL,
   input  wire [7:0]  I_HADDR,
   input  wire [1:0]  I_HTRANS,
   input  wire        I_HWRITE,
   input  wire [2:0]  I_HSIZE,
   input  wire [31:0] I_HWDATA,
   input  wire        I_HREADY,
   output reg  [31:0] O_HRDATA,
   output reg         O_HREADYOUT,
   output reg         O_HRESP,
   // link and button
   input  wire        I_NET_UP,
   input  wire        I_BTN_B,
   // outputs to channels
   output reg  [15:0] O_CH_OUT,
   output reg         O_EXPIRED,
   output reg         O_OP_ALLOW,
   output reg         O_STATUS_LED,
   output reg         O_REBOOT,
   output reg         O_FACTORY,
   output reg         O_IRQ
);
   reg        en_q;
   reg        netloss_en_q;
   reg [31:0] timeout_q;
   reg [31:0] count_q;
   reg [15:0] part_q;
   reg [15:0] expval_q;
   reg [15:0] outval_q;
   reg        expired_q;
   reg [2:0]  irq_stat_q;
   reg [2:0]  irq_mask_q;
   reg        net1_q;
   reg        net2_q;
   reg        net_prev_q;
   // ahb address phase capture
   reg        wr_q;
   reg        rd_q;
   reg [7:0]  addr_q;

   wire       tick;
   wire       led;
   wire       reboot;
   wire       factory;
   wire       refresh;
   wire       net_lost;
   wire       timeout_hit;
   wire       expire_now;
   wire [2:0] irq_ev;
   wire       aphase = I_HSEL & I_HREADY & I_HTRANS[1];

   wdog_tick u_tick (
      .i_clk  (I_MCLK),
      .i_rst_b(I_RST_B),
      .o_tick (tick)
   );

   wdog_button #(.HOLD_CYC(HOLD_CYC)) u_btn (
      .i_clk    (I_MCLK),
      .i_rst_b  (I_RST_B),
      .i_btn_b  (I_BTN_B),
      .o_led    (led),
      .o_reboot (reboot),
      .o_factory(factory)
   );

   // writes other than irq status/mask locked once expired
   assign refresh     = wr_q & (addr_q == `A_REFRESH) & (I_HWDATA == `REFRESH_KEY)
                        & ~expired_q;
   assign net_lost    = net_prev_q & ~net2_q;
   assign timeout_hit = en_q & tick & (count_q == 32'h0000_0000);
   assign expire_now  = ~expired_q & (timeout_hit
                        | (en_q & netloss_en_q & net_lost));
   assign irq_ev      = {reboot & factory, net_lost, expire_now};

   // two-flop synchroniser for the link level
   always @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         net1_q     <= 1'b0;
         net2_q     <= 1'b0;
         net_prev_q <= 1'b0;
      end else begin
         net1_q     <= I_NET_UP;
         net2_q     <= net1_q;
         net_prev_q <= net2_q;
      end
   end

   // ahb-lite: zero wait states, always okay
   always @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         wr_q        <= 1'b0;
         rd_q        <= 1'b0;
         addr_q      <= 8'h00;
         O_HREADYOUT <= 1'b1;
         O_HRESP     <= 1'b0;
      end else begin
         wr_q        <= aphase & I_HWRITE;
         rd_q        <= aphase & ~I_HWRITE;
         addr_q      <= I_HADDR;
         O_HREADYOUT <= 1'b1;
         O_HRESP     <= 1'b0;
      end
   end

   // read data registered in the address phase
   always @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         O_HRDATA <= 32'h0000_0000;
      end else if (aphase & ~I_HWRITE) begin
         case (I_HADDR)
            `A_CTRL:     O_HRDATA <= {30'h0000_0000, netloss_en_q, en_q};
            `A_TIMEOUT:  O_HRDATA <= timeout_q;
            `A_PART:     O_HRDATA <= {16'h0000, part_q};
            `A_EXPVAL:   O_HRDATA <= {16'h0000, expval_q};
            `A_OUTVAL:   O_HRDATA <= {16'h0000, outval_q};
            `A_STATUS:   O_HRDATA <= {29'h0000_0000, led, net2_q, expired_q};
            `A_IRQ_STAT: O_HRDATA <= {29'h0000_0000, irq_stat_q};
            `A_IRQ_MASK: O_HRDATA <= {29'h0000_0000, irq_mask_q};
            `A_COUNT:    O_HRDATA <= count_q;
            default:     O_HRDATA <= 32'h0000_0000;
         endcase
      end else begin
         O_HRDATA <= 32'h0000_0000;
      end
   end

   // configuration registers, frozen once expired except the irq mask
   always @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         en_q         <= 1'b0;
         netloss_en_q <= 1'b0;
         timeout_q    <= `TIMEOUT_RST;
         part_q       <= 16'h0000;
         expval_q     <= 16'h0000;
         outval_q     <= `OUT_RST;
         irq_mask_q   <= 3'h0;
      end else if (wr_q) begin
         if (!expired_q) begin
            case (addr_q)
               `A_CTRL: begin
                  en_q         <= I_HWDATA[`C_EN];
                  netloss_en_q <= I_HWDATA[`C_NETLOSS];
               end
               `A_TIMEOUT: timeout_q <= I_HWDATA;
               `A_PART:    part_q    <= I_HWDATA[15:0];
               `A_EXPVAL:  expval_q  <= I_HWDATA[15:0];
               `A_OUTVAL:  outval_q  <= I_HWDATA[15:0];
               default: ;
            endcase
         end
         if (addr_q == `A_IRQ_MASK)
            irq_mask_q <= I_HWDATA[2:0];
      end
   end

   // timeout counter in 25 ns ticks
   always @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         count_q <= `TIMEOUT_RST;
      end else if (expired_q) begin
         count_q <= 32'h0000_0000;
      end else if (!en_q || refresh) begin
         count_q <= timeout_q;
      end else if (tick && count_q != 32'h0000_0000) begin
         count_q <= count_q - 32'h0000_0001;
      end
   end

   // expiry latch: cleared only by device reset
   always @(posedge I_MCLK) begin
      if (!I_RST_B)
         expired_q <= 1'b0;
      else if (expire_now)
         expired_q <= 1'b1;
   end

   // sticky irq status, write one to clear, set wins
   always @(posedge I_MCLK) begin
      if (!I_RST_B)
         irq_stat_q <= 3'h0;
      else if (wr_q && addr_q == `A_IRQ_STAT)
         irq_stat_q <= (irq_stat_q & ~I_HWDATA[2:0]) | irq_ev;
      else
         irq_stat_q <= irq_stat_q | irq_ev;
   end

   // registered outputs
   always @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         O_CH_OUT     <= `OUT_RST;
         O_EXPIRED    <= 1'b0;
         O_OP_ALLOW   <= 1'b0;
         O_STATUS_LED <= 1'b0;
         O_REBOOT     <= 1'b0;
         O_FACTORY    <= 1'b0;
         O_IRQ        <= 1'b0;
      end else begin
         if (expired_q | expire_now)
            O_CH_OUT <= (part_q & expval_q) | (~part_q & O_CH_OUT);
         else
            O_CH_OUT <= outval_q;
         O_EXPIRED    <= expired_q | expire_now;
         O_OP_ALLOW   <= ~(expired_q | expire_now);
         O_STATUS_LED <= led;
         O_REBOOT     <= reboot;
         O_FACTORY    <= factory;
         O_IRQ        <= |((irq_stat_q | irq_ev) & irq_mask_q);
      end
   end
endmodule

// ### rtl/wdog_regs.vh
/*
 * Constants for the output watchdog supervisor: register offsets, field
 * positions, reset values and timing counts. Assumes a 250 MHz I_MCLK.
 */
// Function
// - expire when no refresh before timeout
// - drive participating outputs to expiry values
// - refuse all operations after expiry (irq status and mask writes are still accepted)
// - 32-bit timeout counter in 25 ns ticks
// - option to expire on network loss
// - each output channel opts into expiry
// - reset after expiry restores default outputs
// - short button press reboots, keeps configuration
// - five second hold lights status, factory reboot
`ifndef WDOG_REGS_VH
`define WDOG_REGS_VH

`define CH_N          16
// register byte offsets
`define A_CTRL        8'h00
`define A_TIMEOUT     8'h04
`define A_REFRESH     8'h08
`define A_PART        8'h0C
`define A_EXPVAL      8'h10
`define A_OUTVAL      8'h14
`define A_STATUS      8'h18
`define A_IRQ_STAT    8'h1C
`define A_IRQ_MASK    8'h20
`define A_COUNT       8'h24
// control fields
`define C_EN          0
`define C_NETLOSS     1
// status/irq fields
`define S_EXPIRED     0
`define S_NETLOSS     1
`define S_LONGPRESS   2
// refresh key
`define REFRESH_KEY   32'h0000_A5A5
// reset values
`define TIMEOUT_RST   32'hFFFF_FFFF
`define OUT_RST       16'h0000
// tick: 25 ns at 4 ns clock period
`define CLK_PS        32'h0000_0FA0
`define TICK_PS       32'h0000_61A8
`define TICK_CYC      ((`TICK_PS + `CLK_PS - 32'h0000_0001) / `CLK_PS)
// button hold: five seconds
`define HOLD_MS       32'h0000_1388
`define HOLD_CYC_DEF  (`HOLD_MS * 32'h0003_D090)
`define DEB_CYC       16'h0400

`endif

// ### rtl/wdog_tick.v
/*
 * Tick generator: a one-cycle pulse every 25 ns worth of clocks.
 * Assumes wdog_regs.vh and a 250 MHz clock.
 */
`timescale 1ns/10ps
`include "wdog_regs.vh"
module wdog_tick (
   // clock and reset
   input  wire       i_clk,
   input  wire       i_rst_b,
   // tick
   output reg        o_tick
);
   reg  [7:0] cnt_q;
   wire [31:0] lim = `TICK_CYC - 32'h0000_0001;

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         cnt_q  <= 8'h00;
         o_tick <= 1'b0;
      end else if (cnt_q == lim[7:0]) begin
         cnt_q  <= 8'h00;
         o_tick <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 8'h01;
         o_tick <= 1'b0;
      end
   end
endmodule

// ### rtl/wdog_button.v
/*
 * Reset push-button handler: synchronises and debounces the button,
 * lights the status lamp after a long hold and requests a reboot on
 * release. Assumes an active-low button pin on another domain.
 */
`timescale 1ns/10ps
`include "wdog_regs.vh"
module wdog_button #(
   parameter [31:0] HOLD_CYC = `HOLD_CYC_DEF
) (
   // clock and reset
   input  wire       i_clk,
   input  wire       i_rst_b,
   // button pin, low while pressed
   input  wire       i_btn_b,
   // results
   output reg        o_led,
   output reg        o_reboot,
   output reg        o_factory
);
   reg        s1_q;
   reg        s2_q;
   reg        st_q;
   reg [15:0] deb_q;
   reg [31:0] hold_q;
   reg        long_q;

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         s1_q      <= 1'b0;
         s2_q      <= 1'b0;
         st_q      <= 1'b0;
         deb_q     <= 16'h0000;
         hold_q    <= 32'h0000_0000;
         long_q    <= 1'b0;
         o_led     <= 1'b0;
         o_reboot  <= 1'b0;
         o_factory <= 1'b0;
      end else begin
         s1_q     <= ~i_btn_b;
         s2_q     <= s1_q;
         o_reboot <= 1'b0;
         o_factory <= 1'b0;
         // debounce: accept a level held DEB_CYC clocks
         if (s2_q == st_q)
            deb_q <= 16'h0000;
         else if (deb_q == `DEB_CYC)
            deb_q <= 16'h0000;
         else
            deb_q <= deb_q + 16'h0001;
         if (s2_q != st_q && deb_q == `DEB_CYC) begin
            st_q <= s2_q;
            if (!s2_q) begin
               o_reboot  <= 1'b1;
               o_factory <= long_q;
               long_q    <= 1'b0;
               o_led     <= 1'b0;
            end
            hold_q <= 32'h0000_0000;
         end else if (st_q && !long_q) begin
            if (hold_q >= HOLD_CYC - 32'h0000_0001) begin
               long_q <= 1'b1;
               o_led  <= 1'b1;
            end else
               hold_q <= hold_q + 32'h0000_0001;
         end
      end
   end
endmodule

// ### bench/wdog_top_chk.sv
/* port checker for wdog_top.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
module wdog_top_chk #(
   parameter [31:0] HOLD_CYC = 32'h0000_1388
) (
   input wire logic        I_MCLK,
   input wire logic        I_RST_B,
   input wire logic        I_HSEL,
   input wire logic [1:0]  I_HTRANS,
   input wire logic        I_HREADY,
   input wire logic [31:0] O_HRDATA,
   input wire logic        O_HREADYOUT,
   input wire logic        O_HRESP,
   input wire logic [15:0] O_CH_OUT,
   input wire logic        O_EXPIRED,
   input wire logic        O_OP_ALLOW,
   input wire logic        O_REBOOT,
   input wire logic        O_FACTORY
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_B);
   sequence s_taken;
      I_HSEL && I_HREADY && I_HTRANS[1];
   endsequence
   sequence s_locked;
      O_EXPIRED [*2];
   endsequence
   c_taken: cover property (s_taken);
   a_zero_wait: assert property (O_HREADYOUT && !O_HRESP)
      else $error("bus stall or error response");
   a_rdata_idle: assert property ((!I_HSEL || !I_HREADY || !I_HTRANS[1])
      |=> O_HRDATA == 32'h0000_0000) else $error("read data outside data phase");
   a_exp_sticky: assert property (O_EXPIRED |=> O_EXPIRED)
      else $error("expiry flag dropped");
   a_outs_held: assert property (s_locked |-> $stable(O_CH_OUT))
      else $error("outputs moved after expiry");
   a_ops_locked: assert property (O_EXPIRED |-> !O_OP_ALLOW)
      else $error("operations allowed after expiry");
   a_reset_dflt: assert property ($rose(I_RST_B) |-> O_CH_OUT == 16'h0000 && !O_EXPIRED)
      else $error("outputs not at default after reset");
   a_reboot_pulse: assert property (O_REBOOT |=> !O_REBOOT)
      else $error("reboot pulse too long");
   a_factory_boot: assert property (O_FACTORY |-> O_REBOOT)
      else $error("factory without reboot");
endmodule
bind wdog_top wdog_top_chk #(.HOLD_CYC(HOLD_CYC)) u_chk (
   .I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS),
   .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
   .O_HRESP(O_HRESP), .O_CH_OUT(O_CH_OUT), .O_EXPIRED(O_EXPIRED),
   .O_OP_ALLOW(O_OP_ALLOW), .O_REBOOT(O_REBOOT), .O_FACTORY(O_FACTORY));

// ### bench/host_ahb.sv
/* host model: single-word ahb-lite master.
   assumes one slave whose hreadyout is hready. */
`timescale 1ns/10ps
module host_ahb (
   input  wire logic        clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [7:0]       haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
   end
   // one transfer at a time, so enable is written on a quiet bus
   // recovery from expiry is left to the bench's reset
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
   endtask
endmodule

// ### bench/output_watchdog_supervisor_tb.sv
/* testbench for wdog_top.
   assumes host_ahb as bus master and a short button hold. */
`timescale 1ns/10ps
`include "wdog_regs.vh"
module output_watchdog_supervisor_tb;
   logic clk;
   logic rst_b = 1'b0;
   logic net_up = 1'b1;
   logic btn_b = 1'b1;
   wire hsel, hwrite, rdy, resp, exp_o, allow, led, reboot, factory, irq;
   wire [7:0] haddr;
   wire [1:0] htrans;
   wire [2:0] hsize;
   wire [31:0] hwdata, hrdata;
   wire [15:0] ch_out;
   int n_errors = 0;
   int compares = 0;
   host_ahb h (.clk(clk), .hready(rdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   wdog_top #(.HOLD_CYC(32'h0000_0BB8)) uut (.I_MCLK(clk), .I_RST_B(rst_b),
      .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(rdy), .O_HRDATA(hrdata),
      .O_HREADYOUT(rdy), .O_HRESP(resp), .I_NET_UP(net_up), .I_BTN_B(btn_b),
      .O_CH_OUT(ch_out), .O_EXPIRED(exp_o), .O_OP_ALLOW(allow),
      .O_STATUS_LED(led), .O_REBOOT(reboot), .O_FACTORY(factory), .O_IRQ(irq));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      h.xfer(1'b1, a, d, q);
   endtask
   task do_reset;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   task wait_hi(input int lim);
      int n;
      n = 0;
      while (exp_o !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   task t_reset;
      logic [31:0] q;
      chk("ch_out", 0, ch_out);
      chk("allow", 1, allow);
      h.xfer(1'b0, `A_TIMEOUT, 0, q);
      chk("timeout", `TIMEOUT_RST, q);
      h.xfer(1'b0, 8'h3C, 0, q);
      chk("unmapped", 0, q);
      $display("t_reset done");
   endtask
   task t_expire;
      logic [31:0] q;
      wr(`A_OUTVAL, 32'h0000_00FF);
      wr(`A_PART, 32'h0000_0F0F);
      wr(`A_EXPVAL, 32'h0000_AAAA);
      wr(`A_IRQ_MASK, 32'h0000_0001);
      wr(`A_TIMEOUT, 32'h0000_0014);
      wr(`A_CTRL, 32'h0000_0001);
      repeat (70) @(posedge clk);
      wr(`A_REFRESH, `REFRESH_KEY);
      repeat (130) @(negedge clk);
      chk("early", 0, exp_o);
      wait_hi(40);
      chk("expired", 1, exp_o);
      chk("ch_exp", 32'h0000_0AFA, ch_out);
      chk("irq", 1, irq);
      chk("allow_exp", 0, allow);
      wr(`A_OUTVAL, 32'h0000_1234);
      h.xfer(1'b0, `A_STATUS, 0, q);
      chk("locked", 32'h0000_0AFA, ch_out);
      chk("status", 1, q[0]);
      wr(`A_IRQ_STAT, 32'h0000_0001);
      repeat (2) @(negedge clk);
      chk("irq_clr", 0, irq);
      do_reset;
      chk("ch_rst", 0, ch_out);
      $display("t_expire done");
   endtask
   task t_net;
      logic [31:0] q;
      wr(`A_CTRL, 32'h0000_0003);
      @(posedge clk);
      net_up <= 1'b0;
      wait_hi(10);
      chk("net_exp", 1, exp_o);
      h.xfer(1'b0, `A_IRQ_STAT, 0, q);
      chk("irq_stat", 32'h0000_0003, q);
      @(posedge clk);
      net_up <= 1'b1;
      do_reset;
      $display("t_net done");
   endtask
   task t_button(input int hold, input logic fac);
      int n;
      @(posedge clk);
      btn_b <= 1'b0;
      repeat (hold) @(posedge clk);
      @(negedge clk);
      chk("led", fac, led);
      @(posedge clk);
      btn_b <= 1'b1;
      n = 0;
      while (reboot !== 1'b1 && n < 1500) begin
         @(negedge clk);
         n++;
      end
      chk("reboot", 1, reboot);
      chk("factory", fac, factory);
      $display("t_button done");
   endtask
   task conclude;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      conclude;
   end
   initial begin
      do_reset;
      t_reset;
      t_expire;
      t_net;
      t_button(1500, 1'b0);
      t_button(4500, 1'b1);
      conclude;
   end
endmodule
